// *** osd_char_gen.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - 252 character cells, each selecting any of 1024 glyphs.
// - Code 00H always blank; code 01H is a fixed test pattern.
// - Video word is 14 bits: glyph code, colour code, one flag.
// - Bits 0-9 code, 10-12 blue/green/red, bit 13 flag.
// - Words 00H-BFH direct or indirect; C0H-FBH only indirectly.
// - Glyph store holds 18 lines of 16 dots for 1024 glyphs.
// - Glyph readout runs in step with the dot clock.
// - Output combines dots, control and flag into RGB, blank, halftone.
// - Dot clock is oscillator clock divided by programmable divider.
// - Divider comes from horizontal size field of glyph size register.
// - Horizontal sync starts a line; vertical sync starts a frame.
// - Video memory is row-major, 21 columns per row, 12 rows.
// - Enable bit gates output at once; oscillator follows at vertical sync.
// - Edge bit picks rising (0) or falling (1) sync edges.
// - Mode bits: 00 background, 10 halftone, 11 both, 01 unused.
// - Horizontal size x1..x4 makes each dot 1..4 clocks wide.
module osd_char_gen #(
    parameter int ROWS = osd_pkg::ROWS,
    parameter int COLS = osd_pkg::COLS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync pins from the video source
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    // Video outputs
    output osd_pkg::osd_pixel_t pixel_out
);

    initial begin
        if (ROWS * COLS > osd_pkg::VRAM_WORDS || COLS > 30 || ROWS > 15) begin
            $error("osd_char_gen: geometry does not fit video memory");
        end
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    osd_pkg::osd_vram_word_t vram [0:osd_pkg::VRAM_WORDS-1];
    logic [15:0] glyph_mem [0:osd_pkg::GLYPHS*osd_pkg::GLYPH_LINES-1];

    function automatic osd_pkg::osd_sel_t osd_decode(input logic [11:0] a);
        osd_pkg::osd_sel_t s;
        s = osd_pkg::OSD_SEL_NONE;
        case (a)
            osd_pkg::OFF_CTRL: s = osd_pkg::OSD_SEL_CTRL;
            osd_pkg::OFF_SIZE: s = osd_pkg::OSD_SEL_SIZE;
            osd_pkg::OFF_VADDR: s = osd_pkg::OSD_SEL_VADDR;
            osd_pkg::OFF_VDATA: s = osd_pkg::OSD_SEL_VDATA;
            osd_pkg::OFF_GADDR: s = osd_pkg::OSD_SEL_GADDR;
            osd_pkg::OFF_GDATA: s = osd_pkg::OSD_SEL_GDATA;
            default: begin
                if (a[11:10] == osd_pkg::WIN_PAGE && a[1:0] == 2'h0 && a[9:2] <= osd_pkg::DIRECT_LAST) begin
                    s = osd_pkg::OSD_SEL_WIN;
                end
            end
        endcase
        return s;
    endfunction

    // ----------------------------------------------------------------
    // Register and bus state
    // ----------------------------------------------------------------
    logic [3:0] ctrl_reg, ctrl_next;
    logic [1:0] hsize_reg, hsize_next;
    logic [7:0] vaddr_reg, vaddr_next;
    logic [14:0] gaddr_reg, gaddr_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic [31:0] rdata_reg, rdata_next;
    logic vram_we, glyph_we;
    logic [7:0] vram_wa;
    osd_pkg::osd_sel_t sel;
    logic access, blocked, bad;
    logic [7:0] cpu_va;

    // ----------------------------------------------------------------
    // Display timing state
    // ----------------------------------------------------------------
    logic [2:0] hs_q, vs_q;
    logic [1:0] div_reg, div_next;
    logic [3:0] dot_reg, dot_next;
    logic [4:0] col_reg, col_next;
    logic [4:0] line_reg, line_next;
    logic [3:0] row_reg, row_next;
    logic first_reg, first_next;
    logic osc_on_reg, osc_on_next;
    logic fetch_d_reg, fetch_valid_reg, fetch_valid_next;
    osd_pkg::osd_vram_word_t word_reg, shown_word_reg, shown_word_next;
    logic [15:0] glyph_q_reg, shown_pat_reg, shown_pat_next;
    logic shown_valid_reg, shown_valid_next;
    osd_pkg::osd_pixel_t pixel_next;
    logic hs_edge, vs_edge, dot_en, fetch, disp_en;
    logic [7:0] fetch_addr;
    logic [14:0] glyph_idx;
    logic [15:0] pattern;
    osd_pkg::osd_flag_mode_t mode;

    assign disp_en = ctrl_reg[osd_pkg::CTRL_EN_BIT];
    assign mode = osd_pkg::osd_flag_mode_t'(ctrl_reg[osd_pkg::CTRL_MODE_LSB +: 2]);

    // ----------------------------------------------------------------
    // Sync inputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hs_q <= 3'h0;
            vs_q <= 3'h0;
        end else begin
            hs_q <= {hs_q[1:0], hsync_pin};
            vs_q <= {vs_q[1:0], vsync_pin};
        end
    end

    // Edge chosen by the polarity bit
    assign hs_edge = ctrl_reg[osd_pkg::CTRL_EDGE_BIT] ? (hs_q[2] & ~hs_q[1]) : (~hs_q[2] & hs_q[1]);
    assign vs_edge = ctrl_reg[osd_pkg::CTRL_EDGE_BIT] ? (vs_q[2] & ~vs_q[1]) : (~vs_q[2] & vs_q[1]);

    // ----------------------------------------------------------------
    // Dot, column, line and row counters
    // ----------------------------------------------------------------
    // Dot strobe every hsize+1 clocks while the oscillator runs
    assign dot_en = osc_on_reg && col_reg <= 5'(COLS) && div_reg == hsize_reg;
    assign fetch = dot_en && dot_reg == 4'h0 && col_reg < 5'(COLS) && row_reg < 4'(ROWS) && disp_en;
    assign fetch_addr = 8'(row_reg * COLS + col_reg);

    always_comb begin
        osc_on_next = osc_on_reg;
        div_next = div_reg;
        dot_next = dot_reg;
        col_next = col_reg;
        line_next = line_reg;
        row_next = row_reg;
        first_next = first_reg;
        if (vs_edge) begin
            osc_on_next = disp_en;
            row_next = 4'h0;
            line_next = 5'h0;
            first_next = 1'b1;
            col_next = 5'(COLS + 1);
        end else if (hs_edge) begin
            col_next = 5'h0;
            dot_next = 4'h0;
            div_next = 2'h0;
            first_next = 1'b0;
            if (!first_reg && row_reg < 4'(ROWS)) begin
                if (line_reg == 5'(osd_pkg::GLYPH_LINES - 1)) begin
                    line_next = 5'h0;
                    row_next = row_reg + 4'h1;
                end else begin
                    line_next = line_reg + 5'h1;
                end
            end
        end else if (osc_on_reg && col_reg <= 5'(COLS)) begin
            div_next = dot_en ? 2'h0 : div_reg + 2'h1;
            if (dot_en) begin
                dot_next = dot_reg + 4'h1;
                if (dot_reg == 4'(osd_pkg::GLYPH_DOTS - 1)) begin
                    col_next = col_reg + 5'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Glyph pipeline and output stage
    // ----------------------------------------------------------------
    assign glyph_idx = 15'(word_reg.code * osd_pkg::GLYPH_LINES + line_reg);

    always_comb begin
        // Reserved codes take a fixed pattern; the glyph store is still read but its output is ignored
        if (word_reg.code == osd_pkg::CODE_BLANK) begin
            pattern = 16'h0000;
        end else if (word_reg.code == osd_pkg::CODE_TEST) begin
            pattern = line_reg[0] ? 16'h5555 : 16'hAAAA;
        end else begin
            pattern = glyph_q_reg;
        end
    end

    // Cell c is fetched while cell c-1 is drawn, hiding the two read stages
    always_comb begin
        logic on;
        logic vis;
        logic use_bg;
        logic use_ht;
        on = 1'b0;
        vis = 1'b0;
        use_bg = 1'b0;
        use_ht = 1'b0;
        shown_pat_next = shown_pat_reg;
        shown_word_next = shown_word_reg;
        shown_valid_next = shown_valid_reg;
        fetch_valid_next = fetch_valid_reg;
        if (hs_edge || vs_edge) begin
            shown_valid_next = 1'b0;
            fetch_valid_next = 1'b0;
        end else if (dot_en && dot_reg == 4'h0) begin
            shown_pat_next = pattern;
            shown_word_next = word_reg;
            shown_valid_next = fetch_valid_reg;
            fetch_valid_next = fetch;
        end
        on = shown_pat_reg[4'hF - dot_reg];
        vis = disp_en && osc_on_reg && shown_valid_reg && col_reg <= 5'(COLS);
        use_bg = shown_word_reg.flag && (mode == osd_pkg::OSD_FLAG_BG || mode == osd_pkg::OSD_FLAG_BOTH);
        use_ht = shown_word_reg.flag && (mode == osd_pkg::OSD_FLAG_HT || mode == osd_pkg::OSD_FLAG_BOTH);
        pixel_next.blank = vis && (on || use_bg);
        pixel_next.halftone = vis && use_ht;
        pixel_next.red = vis && on && shown_word_reg.red;
        pixel_next.green = vis && on && shown_word_reg.green;
        pixel_next.blue = vis && on && shown_word_reg.blue;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            osc_on_reg <= 1'b0;
            div_reg <= 2'h0;
            dot_reg <= 4'h0;
            col_reg <= 5'(COLS + 1);
            line_reg <= 5'h0;
            row_reg <= 4'(ROWS);
            first_reg <= 1'b1;
            fetch_d_reg <= 1'b0;
            fetch_valid_reg <= 1'b0;
            shown_valid_reg <= 1'b0;
            shown_pat_reg <= 16'h0000;
            shown_word_reg <= '0;
            pixel_out <= '0;
        end else begin
            osc_on_reg <= osc_on_next;
            div_reg <= div_next;
            dot_reg <= dot_next;
            col_reg <= col_next;
            line_reg <= line_next;
            row_reg <= row_next;
            first_reg <= first_next;
            fetch_d_reg <= fetch;
            fetch_valid_reg <= fetch_valid_next;
            shown_valid_reg <= shown_valid_next;
            shown_pat_reg <= shown_pat_next;
            shown_word_reg <= shown_word_next;
            pixel_out <= pixel_next;
        end
    end

    // ----------------------------------------------------------------
    // APB register file
    // ----------------------------------------------------------------
    assign sel = osd_decode(paddr);
    assign access = psel && penable && !done_reg;
    assign cpu_va = (sel == osd_pkg::OSD_SEL_WIN) ? paddr[9:2] : vaddr_reg;
    // Display reads own the memories in their slot; the CPU waits a cycle
    assign blocked = ((sel == osd_pkg::OSD_SEL_WIN || sel == osd_pkg::OSD_SEL_VDATA) && fetch)
        || (sel == osd_pkg::OSD_SEL_GDATA && fetch_d_reg);
    assign bad = sel == osd_pkg::OSD_SEL_NONE
        || (sel == osd_pkg::OSD_SEL_VDATA && vaddr_reg > osd_pkg::VRAM_LAST)
        || (sel == osd_pkg::OSD_SEL_GDATA && gaddr_reg >= 15'(osd_pkg::GLYPHS * osd_pkg::GLYPH_LINES));

    always_comb begin
        ctrl_next = ctrl_reg;
        hsize_next = hsize_reg;
        vaddr_next = vaddr_reg;
        gaddr_next = gaddr_reg;
        done_next = access && !blocked;
        err_next = 1'b0;
        rdata_next = rdata_reg;
        vram_we = 1'b0;
        glyph_we = 1'b0;
        vram_wa = cpu_va;
        if (access && !blocked) begin
            err_next = bad;
            rdata_next = 32'h0000_0000;
            if (!bad) begin
                case (sel)
                    osd_pkg::OSD_SEL_CTRL: begin
                        if (pwrite) ctrl_next = pwdata[3:0];
                        rdata_next = {24'h0, row_reg, ctrl_reg};
                    end
                    osd_pkg::OSD_SEL_SIZE: begin
                        if (pwrite) hsize_next = pwdata[osd_pkg::SIZE_H_LSB +: 2];
                        rdata_next = {26'h0, hsize_reg, 4'h0};
                    end
                    osd_pkg::OSD_SEL_VADDR: begin
                        if (pwrite) vaddr_next = pwdata[7:0];
                        rdata_next = {24'h0, vaddr_reg};
                    end
                    osd_pkg::OSD_SEL_GADDR: begin
                        if (pwrite) gaddr_next = pwdata[14:0];
                        rdata_next = {17'h0, gaddr_reg};
                    end
                    osd_pkg::OSD_SEL_GDATA: begin
                        glyph_we = pwrite;
                        rdata_next = {16'h0, glyph_mem[gaddr_reg]};
                    end
                    osd_pkg::OSD_SEL_VDATA, osd_pkg::OSD_SEL_WIN: begin
                        vram_we = pwrite;
                        rdata_next = {18'h0, vram[cpu_va]};
                    end
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= osd_pkg::CTRL_RST;
            hsize_reg <= osd_pkg::SIZE_H_RST;
            vaddr_reg <= 8'h00;
            gaddr_reg <= 15'h0000;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            hsize_reg <= hsize_next;
            vaddr_reg <= vaddr_next;
            gaddr_reg <= gaddr_next;
            done_reg <= done_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    // Memories carry no reset; software clears video words one by one
    always_ff @(posedge mclk) begin
        if (vram_we) vram[vram_wa] <= osd_pkg::osd_vram_word_t'(pwdata[13:0]);
        if (glyph_we) glyph_mem[gaddr_reg] <= pwdata[15:0];
        if (fetch) word_reg <= vram[fetch_addr];
        if (fetch_d_reg) glyph_q_reg <= glyph_mem[glyph_idx];
    end

    assign pready = done_reg;
    assign pslverr = done_reg && err_reg;
    assign prdata = rdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_access;
        psel && penable && !done_reg;
    endsequence
    sequence s_answer;
        ##[1:2] pready;
    endsequence
    property p_cpu_completes;
        @(posedge mclk) disable iff (!rst_b) $rose(psel && penable) |-> s_answer;
    endproperty
    a_cpu_completes: assert property (p_cpu_completes) else $error("APB access not answered");
    property p_fetch_wins;
        @(posedge mclk) disable iff (!rst_b) s_access and (fetch && sel == osd_pkg::OSD_SEL_WIN) |=> !pready;
    endproperty
    a_fetch_wins: assert property (p_fetch_wins) else $error("CPU beat display fetch");
    property p_high_window;
        @(posedge mclk) disable iff (!rst_b) pready && paddr == 12'h700 |-> pslverr;
    endproperty
    a_high_window: assert property (p_high_window) else $error("Direct access above BFH accepted");
    property p_disable_now;
        @(posedge mclk) disable iff (!rst_b) !disp_en |=> pixel_out == '0;
    endproperty
    a_disable_now: assert property (p_disable_now) else $error("Output not stopped by enable bit");
    property p_osc_at_vsync;
        @(posedge mclk) disable iff (!rst_b) $changed(osc_on_reg) |-> $past(vs_edge);
    endproperty
    a_osc_at_vsync: assert property (p_osc_at_vsync) else $error("Oscillator changed off vertical sync");
    property p_fetch_addr;
        @(posedge mclk) disable iff (!rst_b) fetch |-> fetch_addr == row_reg * 21 + col_reg && fetch_addr <= 8'hFB;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("Bad row-major fetch address");
    property p_dot_x2;
        @(posedge mclk) disable iff (!rst_b)
            dot_en && hsize_reg == 2'h1 && !hs_edge && !vs_edge && !(col_reg == 5'(COLS) && dot_reg == 4'hF)
            ##1 !hs_edge && !vs_edge |-> !dot_en ##1 dot_en;
    endproperty
    a_dot_x2: assert property (p_dot_x2) else $error("Dot width not two clocks");
    property p_line_start;
        @(posedge mclk) disable iff (!rst_b) hs_edge && !vs_edge |=> col_reg == 5'h0 && dot_reg == 4'h0;
    endproperty
    a_line_start: assert property (p_line_start) else $error("Sync did not restart the line");
    property p_blank_code;
        @(posedge mclk) disable iff (!rst_b)
            shown_valid_reg && shown_word_reg.code == 10'h000 && !hs_edge |=> !(pixel_out.red || pixel_out.green || pixel_out.blue);
    endproperty
    a_blank_code: assert property (p_blank_code) else $error("Blank glyph produced colour");

endmodule // osd_char_gen

// *** osd_pkg.sv ***
package osd_pkg;

    // ----------------------------------------------------------------
    // Geometry and glyph store
    // ----------------------------------------------------------------
    localparam int VRAM_WORDS = 252;
    localparam int COLS = 21;
    localparam int ROWS = 12;
    localparam int GLYPHS = 1024;
    localparam int GLYPH_LINES = 18;
    localparam int GLYPH_DOTS = 16;
    localparam int GLYPH_IDX_W = 15;
    localparam logic [7:0] DIRECT_LAST = 8'hBF;
    localparam logic [7:0] VRAM_LAST = 8'hFB;
    localparam logic [9:0] CODE_BLANK = 10'h000;
    localparam logic [9:0] CODE_TEST = 10'h001;

    // ----------------------------------------------------------------
    // Register map, field positions, reset values
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_SIZE = 12'h004;
    localparam logic [11:0] OFF_VADDR = 12'h008;
    localparam logic [11:0] OFF_VDATA = 12'h00C;
    localparam logic [11:0] OFF_GADDR = 12'h010;
    localparam logic [11:0] OFF_GDATA = 12'h014;
    localparam logic [1:0] WIN_PAGE = 2'h1;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_ROW_LSB = 4;
    localparam int SIZE_H_LSB = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [1:0] SIZE_H_RST = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OSD_FLAG_BG = 2'b00,
        OSD_FLAG_UNUSED = 2'b01,
        OSD_FLAG_HT = 2'b10,
        OSD_FLAG_BOTH = 2'b11
    } osd_flag_mode_t;

    typedef enum logic [2:0] {
        OSD_SEL_CTRL = 3'b000,
        OSD_SEL_SIZE = 3'b001,
        OSD_SEL_VADDR = 3'b010,
        OSD_SEL_VDATA = 3'b011,
        OSD_SEL_GADDR = 3'b100,
        OSD_SEL_GDATA = 3'b101,
        OSD_SEL_WIN = 3'b110,
        OSD_SEL_NONE = 3'b111
    } osd_sel_t;

    typedef struct packed {
        logic flag;
        logic red;
        logic green;
        logic blue;
        logic [9:0] code;
    } osd_vram_word_t;

    typedef struct packed {
        logic halftone;
        logic blank;
        logic red;
        logic green;
        logic blue;
    } osd_pixel_t;

endpackage

// *** osd_sync_src.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Video sync source model
// ----------------------------------------------------------------
module osd_sync_src (
    // Clock
    input wire logic mclk,
    // Sync pins
    output logic hsync_pin,
    output logic vsync_pin
);
    logic idle = 1'b0;
    initial begin
        hsync_pin = 1'b0;
        vsync_pin = 1'b0;
    end
    // Idle level follows the chosen active edge
    task automatic set_idle(input logic lvl);
        @(posedge mclk);
        idle = lvl;
        hsync_pin <= lvl;
        vsync_pin <= lvl;
    endtask
    // Pulse lasts 4 clocks so the synchroniser cannot miss it
    task automatic pulse(input logic vert);
        @(posedge mclk);
        if (vert) begin
            vsync_pin <= ~idle;
        end else begin
            hsync_pin <= ~idle;
        end
        repeat (4) @(posedge mclk);
        vsync_pin <= idle;
        hsync_pin <= idle;
    endtask
endmodule // osd_sync_src

// *** test_char_osd_generator.sv ***
`timescale 1ns/1ns
module test_char_osd_generator;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hsync_pin;
    logic vsync_pin;
    osd_pkg::osd_pixel_t pixel_out;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [31:0] q;
    logic e;

    always #5 mclk = ~mclk;

    osd_char_gen dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .pixel_out(pixel_out));
    osd_sync_src src_u (.mclk(mclk), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        check("pready", 32'h1, {31'h0, pready});
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, q & m);
    endtask

    task automatic err_chk(input string what, input logic wr, input logic [11:0] a);
        apb(wr, a, 32'h0);
        check(what, 32'h1, {31'h0, e});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd_chk("ctrl_rst", osd_pkg::OFF_CTRL, 32'hF, 32'h0);
        rd_chk("row_rst", osd_pkg::OFF_CTRL, 32'hF0, 32'hC0);
        rd_chk("size_rst", osd_pkg::OFF_SIZE, 32'h30, 32'h0);
        for (int m = 0; m < 16; m++) begin
            apb(1'b1, osd_pkg::OFF_CTRL, 32'(m));
            rd_chk("ctrl", osd_pkg::OFF_CTRL, 32'hF, 32'(m));
        end
        for (int h = 0; h < 4; h++) begin
            apb(1'b1, osd_pkg::OFF_SIZE, 32'(h << 4));
            rd_chk("size", osd_pkg::OFF_SIZE, 32'h30, 32'(h << 4));
        end
    endtask

    task automatic t_vram();
        apb(1'b1, 12'h400 + 12'h2FC, 32'hFFFFFFFF);
        apb(1'b1, osd_pkg::OFF_VADDR, 32'hBF);
        rd_chk("vdata_bf", osd_pkg::OFF_VDATA, 32'hFFFFFFFF, 32'h3FFF);
        apb(1'b1, osd_pkg::OFF_VADDR, 32'hFB);
        apb(1'b1, osd_pkg::OFF_VDATA, 32'h2A55);
        rd_chk("vdata_fb", osd_pkg::OFF_VDATA, 32'hFFFFFFFF, 32'h2A55);
        err_chk("win_c0", 1'b1, 12'h700);
        apb(1'b1, osd_pkg::OFF_VADDR, 32'hFC);
        err_chk("vdata_fc", 1'b0, osd_pkg::OFF_VDATA);
        err_chk("unmapped", 1'b0, 12'h020);
        apb(1'b1, osd_pkg::OFF_GADDR, 32'd18431);
        apb(1'b1, osd_pkg::OFF_GDATA, 32'hBEEF);
        rd_chk("gdata", osd_pkg::OFF_GDATA, 32'hFFFFFFFF, 32'hBEEF);
        apb(1'b1, osd_pkg::OFF_GADDR, 32'd18432);
        err_chk("gaddr_top", 1'b0, osd_pkg::OFF_GDATA);
        // Plain writes are the only way to clear cells
        for (int a = 0; a < 21; a++) begin
            apb(1'b1, 12'h400 + 12'(4 * a), 32'h0);
        end
        apb(1'b1, 12'h400, 32'h3001);
        // Glyph 2, line 0: four leftmost dots lit; cell 1 shows it in green
        apb(1'b1, osd_pkg::OFF_GADDR, 32'd36);
        apb(1'b1, osd_pkg::OFF_GDATA, 32'hF000);
        apb(1'b1, 12'h404, 32'h0802);
    endtask

    // One line: cell 0 test glyph, red, flag set; cell 1 stored glyph, green
    task automatic t_line(input int ctrl, input int hs, input int eb, input int eh, input int er, input int eg);
        int nb;
        int nh;
        int nr;
        int ng;
        int nu;
        nb = 0;
        nh = 0;
        nr = 0;
        ng = 0;
        nu = 0;
        apb(1'b1, osd_pkg::OFF_SIZE, 32'(hs << 4));
        apb(1'b1, osd_pkg::OFF_CTRL, 32'(ctrl));
        src_u.set_idle(ctrl[3]);
        src_u.pulse(1'b1);
        src_u.pulse(1'b0);
        repeat (1500) begin
            @(posedge mclk);
            nb += pixel_out.blank;
            nh += pixel_out.halftone;
            nr += pixel_out.red;
            ng += pixel_out.green;
            nu += pixel_out.blue;
        end
        check("blank", 32'(eb), 32'(nb));
        check("halftone", 32'(eh), 32'(nh));
        check("red", 32'(er), 32'(nr));
        check("green", 32'(eg), 32'(ng));
        check("blue", 32'h0, 32'(nu));
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_vram();
        t_line(5, 0, 12, 16, 8, 4);
        t_line(1, 0, 20, 0, 8, 4);
        t_line(7, 0, 20, 16, 8, 4);
        t_line(3, 0, 12, 0, 8, 4);
        t_line(13, 1, 24, 32, 16, 8);
        t_line(4, 0, 0, 0, 0, 0);
        print_verdict();
    end
endmodule // test_char_osd_generator
